// ### alu_pkg.sv
/*
 * Constants for the accumulator ALU subset: operation codes, widths and reset values.
 * Assumes a single 10 MHz clock domain and no software-visible registers.
 */
package alu_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int BIT_W = 3;
    localparam int OP_W = 3;
    localparam int NIB = 4;
    localparam int MSB = 7;

    localparam logic [OP_W-1:0] OP_NONE = 3'h0;
    localparam logic [OP_W-1:0] OP_ADD_IMM_CARRY = 3'h1;
    localparam logic [OP_W-1:0] OP_ADD_IMM = 3'h2;
    localparam logic [OP_W-1:0] OP_AND_FILE = 3'h3;
    localparam logic [OP_W-1:0] OP_AND_IMM = 3'h4;
    localparam logic [OP_W-1:0] OP_BIT_CLEAR = 3'h5;
    localparam logic [OP_W-1:0] OP_BIT_SET = 3'h6;

    localparam logic DEST_WORKING = 1'h0;

    localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic FLAG_RESET = 1'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_EXEC = 2'h2
    } exec_state_t;

endpackage : alu_pkg

// ### accumulator_alu_op_subset.sv
/*
 * Execution datapath for add-immediate, AND and single-bit clear/set operations.
 * Assumes the caller presents one operation per cycle with op_valid and supplies
 * the addressed file register value on file_rdata in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module accumulator_alu_op_subset #(
    parameter int DATA_W = alu_pkg::DATA_W,
    parameter int ADDR_W = alu_pkg::ADDR_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic op_valid,
    input wire logic [alu_pkg::OP_W-1:0] op_code,
    input wire logic [DATA_W-1:0] imm_data,
    input wire logic [ADDR_W-1:0] file_addr,
    input wire logic [alu_pkg::BIT_W-1:0] bit_sel,
    input wire logic dest_sel,
    input wire logic [DATA_W-1:0] file_rdata,
    output logic [DATA_W-1:0] working_register,
    output logic zero_flag,
    output logic half_sum_flag,
    output logic carry_flag,
    output logic file_we,
    output logic [ADDR_W-1:0] file_waddr,
    output logic [DATA_W-1:0] file_wdata,
    output logic done
);

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        alu_pkg::exec_state_t st;
        logic [DATA_W-1:0] work;
        logic z;
        logic hc;
        logic c;
        logic we;
        logic [ADDR_W-1:0] waddr;
        logic [DATA_W-1:0] wdata;
    } state_t;

    // Result of an addition together with its two carries.
    typedef struct packed {
        logic carry;
        logic half;
        logic [DATA_W-1:0] value;
    } sum_t;

    state_t s_q;
    state_t s_d;

    logic accepted;
    logic carry_in;
    sum_t sum;
    logic [DATA_W-1:0] and_operand;
    logic [DATA_W-1:0] anded;
    logic [DATA_W-1:0] bit_mask;

    ////////////////////////////////////////////////////////////////////////////

    // Adds two bytes and a carry-in, returning the carries out of bit 3 and the top bit.
    function automatic sum_t add_bytes(input logic [DATA_W-1:0] a,
                                       input logic [DATA_W-1:0] b,
                                       input logic cin);
        logic [alu_pkg::NIB:0] lo;
        logic [DATA_W:0] full;
        sum_t res;
        lo = {1'h0, a[alu_pkg::NIB-1:0]} + {1'h0, b[alu_pkg::NIB-1:0]}
             + {{alu_pkg::NIB{1'h0}}, cin};
        full = {1'h0, a} + {1'h0, b} + {{DATA_W{1'h0}}, cin};
        res.carry = full[DATA_W];
        res.half = lo[alu_pkg::NIB];
        res.value = full[DATA_W-1:0];
        return res;
    endfunction : add_bytes

    // Tells whether a byte is all zeros.
    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return (v == alu_pkg::ZERO_BYTE);
    endfunction : is_zero

    // Builds a mask with only the selected bit position set.
    function automatic logic [DATA_W-1:0] one_hot_bit(input logic [alu_pkg::BIT_W-1:0] pos);
        logic [DATA_W-1:0] m;
        m = '0;
        m[pos] = 1'h1;
        return m;
    endfunction : one_hot_bit

    // Tells whether an operation code names one of the executed operations.
    function automatic logic is_known_op(input logic [alu_pkg::OP_W-1:0] code);
        logic known;
        case (code)
            alu_pkg::OP_ADD_IMM_CARRY, alu_pkg::OP_ADD_IMM, alu_pkg::OP_AND_FILE,
            alu_pkg::OP_AND_IMM, alu_pkg::OP_BIT_CLEAR, alu_pkg::OP_BIT_SET:
            begin
                known = 1'h1;
            end
            default:
            begin
                known = 1'h0;
            end
        endcase
        return known;
    endfunction : is_known_op

    // Queues a file register write in a copy of the state.
    function automatic state_t with_write(input state_t s,
                                          input logic [ADDR_W-1:0] addr,
                                          input logic [DATA_W-1:0] data);
        state_t r;
        r = s;
        r.we = 1'h1;
        r.waddr = addr;
        r.wdata = data;
        return r;
    endfunction : with_write

    ////////////////////////////////////////////////////////////////////////////

    // Operand selection and arithmetic shared by the operations.
    assign accepted = op_valid && is_known_op(op_code);
    assign carry_in = (op_code == alu_pkg::OP_ADD_IMM_CARRY) ? s_q.c : 1'h0;
    assign sum = add_bytes(s_q.work, imm_data, carry_in);
    assign and_operand = (op_code == alu_pkg::OP_AND_FILE) ? file_rdata : imm_data;
    assign anded = s_q.work & and_operand;
    assign bit_mask = one_hot_bit(bit_sel);

    ////////////////////////////////////////////////////////////////////////////

    // Next state: one operation per cycle, taking effect at the next edge.
    always_comb
    begin
        s_d = s_q;
        s_d.we = 1'h0;
        s_d.st = accepted ? alu_pkg::ST_EXEC : alu_pkg::ST_IDLE;
        if (op_valid)
        begin
            case (op_code)
                alu_pkg::OP_ADD_IMM_CARRY, alu_pkg::OP_ADD_IMM:
                begin
                    s_d.work = sum.value;
                    s_d.z = is_zero(sum.value);
                    s_d.hc = sum.half;
                    s_d.c = sum.carry;
                end
                alu_pkg::OP_AND_FILE:
                begin
                    s_d.z = is_zero(anded);
                    if (dest_sel == alu_pkg::DEST_WORKING)
                    begin
                        s_d.work = anded;
                    end
                    else
                    begin
                        s_d = with_write(s_d, file_addr, anded);
                    end
                end
                alu_pkg::OP_AND_IMM:
                begin
                    s_d.work = anded;
                    s_d.z = is_zero(anded);
                end
                alu_pkg::OP_BIT_CLEAR:
                begin
                    s_d = with_write(s_d, file_addr, file_rdata & ~bit_mask);
                end
                alu_pkg::OP_BIT_SET:
                begin
                    s_d = with_write(s_d, file_addr, file_rdata | bit_mask);
                end
                default:
                begin
                    s_d.we = 1'h0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // State register, cleared to the documented reset values.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_q.st <= alu_pkg::ST_IDLE;
            s_q.work <= alu_pkg::WORK_RESET;
            s_q.z <= alu_pkg::FLAG_RESET;
            s_q.hc <= alu_pkg::FLAG_RESET;
            s_q.c <= alu_pkg::FLAG_RESET;
            s_q.we <= 1'h0;
            s_q.waddr <= '0;
            s_q.wdata <= alu_pkg::ZERO_BYTE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign working_register = s_q.work;
    assign zero_flag = s_q.z;
    assign half_sum_flag = s_q.hc;
    assign carry_flag = s_q.c;
    assign file_we = s_q.we;
    assign file_waddr = s_q.waddr;
    assign file_wdata = s_q.wdata;
    assign done = (s_q.st == alu_pkg::ST_EXEC);

endmodule : accumulator_alu_op_subset

`default_nettype wire

// ### accumulator_alu_properties.sv
/* Checker for the accumulator ALU subset, bound to its top module.
   Assumes one clock domain with reset_n active low. */
`timescale 1ns/1ps
`default_nettype none
module accumulator_alu_properties (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic [7:0] imm_data,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] working_register,
    input wire logic zero_flag,
    input wire logic half_sum_flag,
    input wire logic carry_flag,
    input wire logic file_we,
    input wire logic [7:0] file_wdata,
    input wire logic done
);
default clocking @(posedge clk); endclocking
default disable iff (!reset_n);
logic v;
assign v = op_valid && op_code inside {[3'h1:3'h6]};
a_done_pulse: assert property (v |=> done) else $error("done missing");
a_no_done: assert property (!v |=> !done) else $error("stray done");
a_add_sum: assert property (op_valid && op_code == 3'h2 |=>
    working_register == $past(working_register) + $past(imm_data)) else $error("add wrong");
a_adc_sum: assert property (op_valid && op_code == 3'h1 |=> {carry_flag, working_register} ==
    $past(working_register) + $past(imm_data) + $past(carry_flag)) else $error("adc wrong");
a_and_imm: assert property (op_valid && op_code == 3'h4 |=>
    working_register == ($past(working_register) & $past(imm_data))) else $error("and wrong");
a_zero_set: assert property (op_valid && op_code inside {3'h1, 3'h2, 3'h4} |=>
    zero_flag == (working_register == 8'h00)) else $error("zero wrong");
a_bit_clr: assert property (op_valid && op_code == 3'h5 |=> file_we &&
    file_wdata == ($past(file_rdata) & ~(8'h01 << $past(bit_sel)))) else $error("clear wrong");
a_bit_set: assert property (op_valid && op_code == 3'h6 |=> file_we &&
    file_wdata == ($past(file_rdata) | (8'h01 << $past(bit_sel)))) else $error("set wrong");
a_flags_kept: assert property (op_valid && op_code inside {3'h5, 3'h6} |=>
    $stable({zero_flag, half_sum_flag, carry_flag})) else $error("flags moved");
a_half_sum: assert property (op_valid && op_code inside {3'h1, 3'h2} |=>
    half_sum_flag == ($past(working_register[3:0]) + $past(imm_data[3:0]) +
    ($past(op_code) == 3'h1 ? $past(carry_flag) : 1'b0) > 5'h0F)) else $error("half wrong");
a_and_file: assert property (op_valid && op_code == 3'h3 |=>
    zero_flag == (($past(working_register) & $past(file_rdata)) == 8'h00)) else $error("and file wrong");
c_back: cover property (v ##1 v);
c_write: cover property (file_we);
c_adc: cover property (op_valid && op_code == 3'h1 && carry_flag);
endmodule : accumulator_alu_properties
bind accumulator_alu_op_subset accumulator_alu_properties u_accumulator_alu_properties (.clk,
    .reset_n, .op_valid, .op_code, .imm_data, .bit_sel, .file_rdata, .working_register,
    .zero_flag, .half_sum_flag, .carry_flag, .file_we, .file_wdata, .done);
`default_nettype wire

// ### accumulator_alu_op_subset_tb.sv
/* Self-checking bench for the accumulator ALU subset.
   Assumes the package and design are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module accumulator_alu_op_subset_tb;
logic clk = 0, reset_n = 0, op_valid = 0, dest_sel = 0, c = 0, h = 0, z = 0, we;
logic [2:0] op_code = 0, bit_sel = 0;
logic [7:0] imm_data = 0, file_rdata = 0, w = 0, r, working_register, file_wdata;
logic [6:0] file_addr = 0, file_waddr, a;
logic zero_flag, half_sum_flag, carry_flag, file_we, done;
logic [18:0] q[$];
int miscompares = 0, cmp_count = 0, cyc = 0;
always #50 clk = ~clk;
accumulator_alu_op_subset u_accumulator_alu_op_subset (.clk, .reset_n, .op_valid, .op_code,
    .imm_data, .file_addr, .bit_sel, .dest_sel, .file_rdata, .working_register, .zero_flag,
    .half_sum_flag, .carry_flag, .file_we, .file_waddr, .file_wdata, .done);
task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
        miscompares++;
        $display("[FAIL] %0t saw %h wanted %h", $time, seen, exp);
    end
endtask : check
task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask : wrap_up
task automatic op(input logic [2:0] k, input logic [7:0] i, d, input logic [2:0] b, input logic s);
    a = 7'($urandom);
    r = 8'h00;
    if (k == 3'h1 || k == 3'h2)
    begin
        h = (w[3:0] + i[3:0] + (k == 3'h1 ? c : 1'b0)) > 5'h0F;
        {c, w} = w + i + (k == 3'h1 ? c : 1'b0);
        z = w == 8'h00;
    end
    else if (k == 3'h4 || k == 3'h3)
    begin
        r = w & (k == 3'h4 ? i : d);
        z = r == 8'h00;
        if (k == 3'h4 || !s) w = r;
    end
    else if (k == 3'h5) r = d & ~(8'h01 << b);
    else if (k == 3'h6) r = d | (8'h01 << b);
    we = k > 3'h4 || (k == 3'h3 && s);
    if (k inside {[3'h1:3'h6]}) q.push_back({we, we ? a : 7'h00, we ? r : w, z, h, c});
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= k;
    imm_data <= i;
    file_rdata <= d;
    bit_sel <= b;
    dest_sel <= s;
    file_addr <= a;
endtask : op
always @(negedge clk)
    if (done === 1'b1)
        check({file_we, file_we ? file_waddr : 7'h00, file_we ? file_wdata : working_register,
            zero_flag, half_sum_flag, carry_flag}, q.pop_front());
always @(negedge clk)
    if (++cyc > 1000)
    begin
        miscompares++;
        wrap_up();
    end
initial
begin
    void'($urandom(34));
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    op(3'h2, 8'hFF, 8'h00, 3'h0, 1'b0);
    op(3'h2, 8'h13, 8'h00, 3'h0, 1'b0);
    op(3'h1, 8'h34, 8'h00, 3'h0, 1'b0);
    op(3'h6, 8'h00, 8'h5A, 3'h2, 1'b0);
    op(3'h5, 8'h00, 8'h5A, 3'h3, 1'b0);
    op(3'h3, 8'h00, 8'hAF, 3'h0, 1'b1);
    op(3'h0, 8'h11, 8'h22, 3'h1, 1'b0);
    op(3'h7, 8'h11, 8'h22, 3'h1, 1'b1);
    $display("test directed done");
    repeat (300) op(3'($urandom), 8'($urandom), 8'($urandom), 3'($urandom), 1'($urandom));
    @(posedge clk);
    op_valid <= 1'b0;
    repeat (3) @(posedge clk);
    check(19'(q.size()), 19'h00000);
    $display("test random done");
    wrap_up();
end
endmodule : accumulator_alu_op_subset_tb
`default_nettype wire
